// *** design/rtcm_pkg.sv ***
// Register map and constants for the RTC mode and interrupt setup block
package rtcm_pkg;
  // Byte address = {register_select, index, 2'b00}
  localparam int ADDR_W = 8;
  localparam logic [4:0] IDX_RTMODE = 5'h01;
  localparam logic [4:0] IDX_PFLAG = 5'h03;
  localparam logic [4:0] IDX_PIE = 5'h03;
  localparam logic [4:0] IDX_CIE = 5'h04;
  localparam logic [4:0] IDX_STAT = 5'h10;
  localparam logic [4:0] IDX_TEST = 5'h1f;
  localparam logic RS_RTMODE = 1'b1;
  localparam logic RS_PFLAG = 1'b0;
  localparam logic RS_PIE = 1'b1;
  localparam logic RS_CIE = 1'b1;
  localparam logic RS_STAT = 1'b1;
  // Bit positions
  localparam int PF_TEST_B = 7;
  localparam int PF_OSC_B = 6;
  localparam int RTM_BKUP_B = 4;
  localparam int RTM_CLK_B = 3;
  localparam int CIE_PF_B = 7;
  localparam int CIE_ALM_B = 6;
  localparam int TST_OSCDIS_B = 0;
  localparam int NPER = 6;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_SINGLE = 1'b1;
  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_TAKE = 2'h1,
    WS_RESP = 2'h3
  } rtcm_wstate_t;
endpackage

// *** design/rtcm_top.sv ***
// RTC mode, test and interrupt enable control with an AXI4-Lite slave
`timescale 1ns/1ps
module rtcm_top
  import rtcm_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Oscillator, counters and supply
  input wire logic osc_running_i,
  input wire logic [NPER-1:0] rollover_i,
  input wire logic [5:0] counter_eq_i,
  input wire logic battery_above_main_i,
  // Control and interrupt outputs
  output logic clock_run_o,
  output logic test_mode_o,
  output logic osc_fail_disable_o,
  output logic battery_backed_o,
  output logic power_fail_input_en_o,
  output logic [5:0] compare_eq_o,
  output logic periodic_irq_o,
  output logic alarm_irq_o,
  output logic power_fail_irq_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic rs,
                               input logic [4:0] idx);
    hit = (a[1:0] == 2'h0) && (a[7] == rs) && (a[6:2] == idx);
  endfunction

  // The test register answers on either register select
  function automatic logic tst_hit(input logic [ADDR_W-1:0] a);
    tst_hit = (a[1:0] == 2'h0) && (a[6:2] == IDX_TEST);
  endfunction

  rtcm_wstate_t ws_q, ws_d;
  logic [7:0] rtm_q;
  logic [7:0] pie_q;
  logic [7:0] cie_q;
  logic [7:0] tst_q;
  logic test_q;
  logic batt_q;
  logic [NPER-1:0] pflag_q;
  logic awready_q, arready_q, rvalid_q, bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q, bresp_q;
  logic per_irq_q, alm_irq_q, pf_irq_q;
  logic [5:0] ceq_q;

  // Write decode
  // Address and data still stand through the take cycle, so they are decoded live
  wire wr_fire = (ws_q == WS_TAKE);
  wire [7:0] wb = s_axi_wdata_i[7:0];
  wire wlane = s_axi_wstrb_i[0];
  wire w_rtm = wr_fire && wlane && hit(s_axi_awaddr_i, RS_RTMODE, IDX_RTMODE);
  wire w_pfl = wr_fire && wlane && hit(s_axi_awaddr_i, RS_PFLAG, IDX_PFLAG);
  wire w_pie = wr_fire && wlane && hit(s_axi_awaddr_i, RS_PIE, IDX_PIE);
  wire w_cie = wr_fire && wlane && hit(s_axi_awaddr_i, RS_CIE, IDX_CIE);
  wire w_tst = wr_fire && wlane && tst_hit(s_axi_awaddr_i);
  wire w_ok = hit(s_axi_awaddr_i, RS_RTMODE, IDX_RTMODE)
              || hit(s_axi_awaddr_i, RS_PFLAG, IDX_PFLAG)
              || hit(s_axi_awaddr_i, RS_PIE, IDX_PIE)
              || hit(s_axi_awaddr_i, RS_CIE, IDX_CIE)
              || hit(s_axi_awaddr_i, RS_STAT, IDX_STAT)
              || tst_hit(s_axi_awaddr_i);

  // Oscillator fail is masked only by the test-mode disable
  wire osc_fail = !osc_running_i && !tst_q[TST_OSCDIS_B];
  wire standby = batt_q && battery_above_main_i;

  // During standby the backup bit stands in for the enables
  wire pf_en = standby ? rtm_q[RTM_BKUP_B] : cie_q[CIE_PF_B];
  wire alm_en = standby ? rtm_q[RTM_BKUP_B] : cie_q[CIE_ALM_B];
  wire [NPER-1:0] per_en = standby ? {NPER{rtm_q[RTM_BKUP_B]}} : pie_q[NPER-1:0];

  // Compare: disabled comparators report equal
  wire [5:0] ceq = ~cie_q[5:0] | counter_eq_i;
  wire alarm_hit = alm_en && (|cie_q[5:0]) && (&ceq);

  // Read decode
  wire rd_take = s_axi_arvalid_i && arready_q;
  wire r_rtm = hit(s_axi_araddr_i, RS_RTMODE, IDX_RTMODE);
  wire r_pfl = hit(s_axi_araddr_i, RS_PFLAG, IDX_PFLAG);
  wire r_pie = hit(s_axi_araddr_i, RS_PIE, IDX_PIE);
  wire r_cie = hit(s_axi_araddr_i, RS_CIE, IDX_CIE);
  wire r_sta = hit(s_axi_araddr_i, RS_STAT, IDX_STAT);
  wire r_tst = tst_hit(s_axi_araddr_i);
  wire r_ok = r_rtm || r_pfl || r_pie || r_cie || r_sta || r_tst;
  wire [7:0] pfl_rd = {test_q, osc_fail, 6'h00} | {2'h0, pflag_q};
  wire [7:0] sta_rd = {3'h0, standby, osc_fail, !batt_q, test_q, rtm_q[RTM_CLK_B]};
  wire [7:0] rd_byte = r_rtm ? rtm_q :
                       r_pfl ? pfl_rd :
                       r_pie ? pie_q :
                       r_cie ? cie_q :
                       r_sta ? sta_rd :
                       r_tst ? tst_q : RST_BYTE;
  wire pfl_clr = rd_take && r_pfl;

  // Write channel sequencing: take address and data together
  always_comb begin
    ws_d = ws_q;
    case (ws_q)
      WS_IDLE: begin
        if (s_axi_awvalid_i && s_axi_wvalid_i) begin
          ws_d = WS_TAKE;
        end
      end
      WS_TAKE: begin
        ws_d = WS_RESP;
      end
      WS_RESP: begin
        if (s_axi_bready_i) begin
          ws_d = WS_IDLE;
        end
      end
      default: begin
        ws_d = WS_IDLE;
      end
    endcase
  end

  // Write state and its ready strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ws_q <= WS_IDLE;
      awready_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      awready_q <= (ws_d == WS_TAKE);
    end
  end

  // Write response, captured while address and data still stand
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      bvalid_q <= (ws_d == WS_RESP);
      if (wr_fire) begin
        bresp_q <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel
  // No new address is taken while an answer still waits for rready
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid_i && !arready_q && !rvalid_q;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h0, rd_byte};
        rresp_q <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Real time mode register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rtm_q <= RST_BYTE;
    end else if (w_rtm) begin
      rtm_q[7:4] <= wb[7:4];
      rtm_q[2:0] <= wb[2:0];
      // A start is refused while the oscillator has failed
      rtm_q[RTM_CLK_B] <= wb[RTM_CLK_B] && !osc_fail;
    end
  end

  // Periodic and compare enables
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pie_q <= RST_BYTE;
      cie_q <= RST_BYTE;
    end else begin
      if (w_pie) begin
        pie_q <= wb;
      end
      if (w_cie) begin
        cie_q <= wb;
      end
    end
  end

  // Test mode and supply selection share the periodic flag register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      test_q <= 1'b0;
      batt_q <= !RST_SINGLE;
    end else if (w_pfl) begin
      test_q <= wb[PF_TEST_B];
      if (wb[PF_OSC_B]) begin
        batt_q <= 1'b0;
      end else if (!osc_fail) begin
        batt_q <= 1'b1;
      end
    end
  end

  // Test conditions only change while test mode is entered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tst_q <= RST_BYTE;
    end else if (w_tst && test_q) begin
      tst_q <= wb;
    end
  end

  // Periodic flags: rollover sets, read clears, set wins
  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++) begin : g_per
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          pflag_q[gi] <= 1'b0;
        end else if (rollover_i[gi] && per_en[gi]) begin
          pflag_q[gi] <= 1'b1;
        end else if (pfl_clr) begin
          pflag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt and status outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      per_irq_q <= 1'b0;
      alm_irq_q <= 1'b0;
      pf_irq_q <= 1'b0;
      ceq_q <= 6'h00;
    end else begin
      per_irq_q <= |(pflag_q & per_en);
      alm_irq_q <= alarm_hit;
      pf_irq_q <= pf_en && battery_above_main_i;
      ceq_q <= ceq;
    end
  end

  // Every output leaves straight from a flop
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = awready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign clock_run_o = rtm_q[RTM_CLK_B];
  assign test_mode_o = test_q;
  assign osc_fail_disable_o = tst_q[TST_OSCDIS_B];
  assign battery_backed_o = batt_q;
  assign power_fail_input_en_o = cie_q[CIE_PF_B];
  assign compare_eq_o = ceq_q;
  assign periodic_irq_o = per_irq_q;
  assign alarm_irq_o = alm_irq_q;
  assign power_fail_irq_o = pf_irq_q;

endmodule

// *** tb/rtcm_chk.sv ***
// Port assertions for the RTC mode and interrupt setup block
`timescale 1ns/1ps
module rtcm_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic osc_running_i,
  input wire logic battery_above_main_i,
  input wire logic [5:0] counter_eq_i,
  input wire logic clock_run_o,
  input wire logic test_mode_o,
  input wire logic osc_fail_disable_o,
  input wire logic battery_backed_o,
  input wire logic power_fail_input_en_o,
  input wire logic [5:0] compare_eq_o,
  input wire logic power_fail_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence w_walk; s_axi_awready_o ##1 s_axi_bvalid_o; endsequence
  sequence r_walk; s_axi_arready_o ##1 s_axi_rvalid_o; endsequence
  wr_resp_a: assert property (s_axi_awready_o |-> w_walk) else $error("no write resp");
  rd_resp_a: assert property (s_axi_arready_o |-> r_walk) else $error("no read resp");
  clk_gate_a: assert property ($rose(clock_run_o) |-> $past(osc_running_i | osc_fail_disable_o))
    else $error("clock start without osc");
  batt_gate_a: assert property ($rose(battery_backed_o) |-> $past(osc_running_i | osc_fail_disable_o))
    else $error("backup with osc fail");
  test_clr_a: assert property ($rose(osc_fail_disable_o) |-> $past(test_mode_o))
    else $error("test bit outside test");
  pf_irq_a: assert property (power_fail_irq_o |-> $past(battery_above_main_i))
    else $error("pf irq without cause");
  pf_arm_a: assert property (!battery_backed_o && power_fail_input_en_o && battery_above_main_i
    |=> power_fail_irq_o) else $error("pf irq missing");
  cmp_all_a: assert property (&counter_eq_i |=> &compare_eq_o) else $error("compare lost");
endmodule
bind rtcm_top rtcm_chk i_chk (.*);

// *** tb/rtcm_osc_model.sv ***
// Crystal oscillator start-up model facing the RTC setup block
`timescale 1ns/1ps
module rtcm_osc_model #(
  parameter int START_CYC = 150
) (
  input wire logic clock_i,
  input wire logic rst_i,
  output logic osc_running_o
);
  int cnt_q;
  // Crystal is slow to swing, so the host has to keep retrying the start
  always_ff @(posedge clock_i) begin
    if (rst_i) cnt_q <= 0;
    else if (cnt_q < START_CYC) cnt_q <= cnt_q + 1;
  end
  assign osc_running_o = (cnt_q >= START_CYC);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the RTC mode and interrupt setup block
`timescale 1ns/1ps
module testbench;
  import rtcm_pkg::*;
  logic clock_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, battery_above_main_i = 0, osc_running_i;
  logic [ADDR_W-1:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, seen;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic [5:0] rollover_i = 0, counter_eq_i = 0, compare_eq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic clock_run_o, test_mode_o, osc_fail_disable_o, battery_backed_o, power_fail_input_en_o;
  logic periodic_irq_o, alarm_irq_o, power_fail_irq_o;
  int bad_count = 0, compares = 0;
  rtcm_top i_dut (.*);
  rtcm_osc_model #(.START_CYC(150)) i_osc (.clock_i(clock_i), .rst_i(rst_i),
    .osc_running_o(osc_running_i));
  initial forever #5 clock_i = ~clock_i;
  task print_verdict;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  function logic sel(int k);
    return k == 0 ? s_axi_awready_o : k == 1 ? s_axi_bvalid_o
      : k == 2 ? s_axi_arready_o : s_axi_rvalid_o;
  endfunction
  // Looks at handshakes on the falling edge so no edge race decides the outcome
  task wt(input int k);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
      if (n > 200) begin bad_count++; print_verdict; end
    end while (sel(k) !== 1'h1);
    seen = s_axi_rdata_o;
    resp = (k == 1) ? s_axi_bresp_o : s_axi_rresp_o;
    @(posedge clock_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw_p, w_p, aw_t, w_t;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    // Each channel is released on its own once its ready has been seen
    while (aw_p || w_p) begin
      @(negedge clock_i);
      n++;
      if (n > 200) begin
        bad_count++;
        print_verdict;
      end
      aw_t = aw_p && s_axi_awready_o === 1'b1;
      w_t = w_p && s_axi_wready_o === 1'b1;
      @(posedge clock_i);
      if (aw_t) begin
        s_axi_awvalid_i <= 0;
        aw_p = 1'b0;
      end
      if (w_t) begin
        s_axi_wvalid_i <= 0;
        w_p = 1'b0;
      end
    end
    wt(1);
    s_axi_bready_i <= 0;
    @(posedge clock_i);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    wt(2);
    s_axi_arvalid_i <= 0;
    wt(3);
    s_axi_rready_i <= 0;
    @(posedge clock_i);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task pulse(input logic [5:0] v);
    rollover_i <= v;
    @(posedge clock_i);
    rollover_i <= 0;
    cyc(3);
  endtask
  task t_test;
    wr(8'h7c, 8'h01);
    chk("osc_fail_disable_o", 0, osc_fail_disable_o);
    wr(8'h0c, 8'hc0);
    chk("test_mode_o", 1, test_mode_o);
    wr(8'h7c, 8'h01);
    chk("osc_fail_disable_o", 1, osc_fail_disable_o);
    wr(8'h7c, 8'h00);
    chk("osc_fail_disable_o", 0, osc_fail_disable_o);
    wr(8'h0c, 8'h40);
    chk("test_mode_o", 0, test_mode_o);
  endtask
  task t_clk;
    rd(8'h0c);
    chk("flags", 32'h40, seen);
    wr(8'h0c, 8'h00);
    chk("battery_backed_o", 0, battery_backed_o);
    wr(8'h84, 8'h08);
    chk("clock_run_o", 0, clock_run_o);
    for (int i = 0; i < 50 && seen[6] !== 1'h0; i++) begin
      wr(8'h84, 8'h08);
      rd(8'h0c);
    end
    wr(8'h84, 8'h08);
    chk("flags", 32'h00, seen);
    chk("clock_run_o", 1, clock_run_o);
    wr(8'h0c, 8'h00);
    chk("battery_backed_o", 1, battery_backed_o);
    wr(8'h0c, 8'h40);
    rd(8'hc0);
    chk("status", 32'h05, seen);
    wr(8'h00, 8'h11);
    chk("bresp", RESP_SLVERR, resp);
    rd(8'h00);
    chk("rresp", RESP_SLVERR, resp);
    wr(8'h0c, 8'h00);
    chk("battery_backed_o", 1, battery_backed_o);
  endtask
  task t_pf;
    wr(8'h90, 8'h80);
    rd(8'h90);
    chk("compare enables", 32'h80, seen);
    chk("power_fail_input_en_o", 1, power_fail_input_en_o);
    battery_above_main_i <= 1;
    cyc(3);
    chk("power_fail_irq_o", 0, power_fail_irq_o);
    wr(8'h84, 8'h18);
    cyc(2);
    chk("power_fail_irq_o", 1, power_fail_irq_o);
    wr(8'h84, 8'h08);
    wr(8'h0c, 8'h40);
    cyc(2);
    chk("power_fail_irq_o", 1, power_fail_irq_o);
    battery_above_main_i <= 0;
    cyc(3);
    chk("power_fail_irq_o", 0, power_fail_irq_o);
  endtask
  task t_cmp;
    wr(8'h90, 8'h40);
    counter_eq_i <= 6'h3f;
    cyc(3);
    chk("alarm_irq_o", 0, alarm_irq_o);
    counter_eq_i <= 6'h00;
    cyc(3);
    chk("compare_eq_o", 6'h3f, compare_eq_o);
    wr(8'h90, 8'h41);
    cyc(2);
    chk("compare_eq_o", 6'h3e, compare_eq_o);
    counter_eq_i <= 6'h01;
    cyc(3);
    chk("alarm_irq_o", 1, alarm_irq_o);
  endtask
  task t_per;
    wr(8'h8c, 8'hc4);
    rd(8'h8c);
    chk("periodic enables", 32'hc4, seen);
    pulse(6'h04);
    chk("periodic_irq_o", 1, periodic_irq_o);
    rd(8'h0c);
    chk("flags", 32'h04, seen);
    cyc(2);
    chk("periodic_irq_o", 0, periodic_irq_o);
    pulse(6'h20);
    chk("periodic_irq_o", 0, periodic_irq_o);
    wr(8'h8c, 8'h00);
    pulse(6'h04);
    chk("periodic_irq_o", 0, periodic_irq_o);
  endtask
  initial begin
    cyc(16);
    rst_i <= 0;
    cyc(1);
    chk("battery_backed_o", 0, battery_backed_o);
    t_test;
    t_clk;
    t_pf;
    t_cmp;
    t_per;
    print_verdict;
  end
endmodule
